// file: src/ddcpm_pkg.sv
// shared constants and types for the ddc power meter and gain loop
package ddcpm_pkg;
  // bus and datapath widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SMP_W = 16;
  localparam int AGC_W = 18;
  localparam int TOT_W = 48;
  localparam int ACC_W = 24;
  localparam int GAIN_W = 16;

  // documented register offsets
  localparam logic [7:0] REG_PM_LEN = 8'h02;
  localparam logic [7:0] REG_PM_DLY = 8'h03;
  localparam logic [7:0] REG_CIC = 8'h0e;
  localparam logic [7:0] REG_MISC = 8'h19;
  localparam logic [7:0] REG_AGC_STEP = 8'h1d;
  localparam logic [7:0] REG_AGC_THR = 8'h1e;
  // added registers: result words, status, loop control, gain
  localparam logic [7:0] REG_TOT_A0 = 8'h20;
  localparam logic [7:0] REG_TOT_A1 = 8'h21;
  localparam logic [7:0] REG_TOT_A2 = 8'h22;
  localparam logic [7:0] REG_TOT_B0 = 8'h23;
  localparam logic [7:0] REG_TOT_B1 = 8'h24;
  localparam logic [7:0] REG_TOT_B2 = 8'h25;
  localparam logic [7:0] REG_STATUS = 8'h26;
  localparam logic [7:0] REG_AGC_CTL = 8'h27;
  localparam logic [7:0] REG_AGC_GAIN = 8'h28;
  localparam logic [7:0] REG_AGC_CUR = 8'h29;

  // field positions
  localparam int DLY_LSB = 8;
  localparam int INTV_LSB = 0;
  localparam int CIC_GAIN_BIT = 5;
  localparam int TEST_BIT = 10;
  localparam int DBELOW_LSB = 12;
  localparam int DABOVE_LSB = 8;
  localparam int DZERO_LSB = 4;
  localparam int DSAT_LSB = 0;
  localparam int ZMSK_LSB = 12;
  localparam int RND_LSB = 8;
  localparam int THR_LSB = 0;
  localparam int CTL_FREEZE_BIT = 0;
  localparam int CTL_CLEAR_BIT = 1;
  localparam int CTL_CDMA_BIT = 2;
  localparam int CTL_SYNC_DIS_BIT = 3;
  localparam int CTL_ZCNT_LSB = 4;
  localparam int CTL_MCNT_LSB = 8;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_RUN_BIT = 1;

  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h1000;
  localparam logic [15:0] RST_AGC_CTL = 16'h0001;

  // scaling
  localparam int INTV_UNIT_LOG2 = 10;
  localparam int CIC_SHIFT = 2;
  localparam int GAIN_FRAC = 12;
  localparam int ACC_EXT = 8;
  localparam int TOP8_LSB = 9;

  // input sample group
  typedef struct packed {
    logic valid;
    logic signed [SMP_W-1:0] ia;
    logic signed [SMP_W-1:0] qa;
    logic signed [SMP_W-1:0] ib;
    logic signed [SMP_W-1:0] qb;
  } ddcpm_smp_t;

  // gain loop output group
  typedef struct packed {
    logic valid;
    logic signed [AGC_W-1:0] i;
    logic signed [AGC_W-1:0] q;
  } ddcpm_agc_t;

  // power meter sequence states
  typedef enum logic [1:0] {PM_IDLE, PM_DELAY, PM_RUN, PM_HOLD} ddcpm_pm_t;
endpackage : ddcpm_pkg

// file: src/ddcpm_top.sv
// ddc channel power meter and automatic gain control loop
// Behaviour
// - integration length is sixteen-bit count of sets
// - cdma: signal and diversity powers summed separately
// - umts: every i/q pair squared into one total
// - integration starts on sync or interval start
// - on completion totals readable and done pulse
// - eight-bit delay at bit 8 after sync
// - interval eight bits, 1024-sample units, exceeds length
// - delayed sync start, restart at interval limit
// - cic gain bit 5 adds fixed 12 dB
// - below threshold: add shifted gain step
// - above threshold: subtract shifted gain step
// - persistent zero: add zero step
// - persistent full scale: subtract saturation step
// - four-bit mask zeroes small magnitude bits
// - output rounded to 18 minus rounding setting bits
// - threshold versus top eight magnitude bits
// - freeze stops adapting, fixed gain multiply
// - zero step after programmed zero occurrences
// - saturation step after programmed full-scale occurrences
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module ddcpm_top (
  input wire logic i_clk, // 125 MHz sample clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic [7:0] i_addr, // register address
  input wire logic [15:0] i_wr_data, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [15:0] o_rd_data, // read data, cycle after strobe
  input wire logic i_pm_sync, // selected meter sync, same clock
  input wire ddcpm_pkg::ddcpm_smp_t i_smp, // samples from filter chain
  output ddcpm_pkg::ddcpm_agc_t o_agc, // gain loop output
  output logic o_pm_done, // one-cycle integration done pulse
  output logic o_test_ena // test bit, kept low by software
);

  // configuration registers
  logic [15:0] pm_len_r; // integration length in sets
  logic [15:0] pm_dly_r; // delay and interval
  logic [15:0] cic_r; // cic gain control word
  logic [15:0] misc_r; // miscellaneous control word
  logic [15:0] step_r; // loop step sizes
  logic [15:0] thr_r; // threshold, rounding, zero mask
  logic [15:0] ctl_r; // loop and meter control
  logic [15:0] gain_r; // programmed gain, 4.12
  // power meter state
  ddcpm_pkg::ddcpm_pm_t pm_st_r; // meter sequence state
  logic [7:0] dly_cnt_r; // samples since sync
  logic [17:0] intv_cnt_r; // samples since last start
  logic [15:0] set_cnt_r; // completed sets
  logic half_r; // umts pair half of a set
  logic [ddcpm_pkg::TOT_W-1:0] acc_a_r; // running total a
  logic [ddcpm_pkg::TOT_W-1:0] acc_b_r; // running total b
  logic [ddcpm_pkg::TOT_W-1:0] tot_a_r; // published total a
  logic [ddcpm_pkg::TOT_W-1:0] tot_b_r; // published total b
  logic done_sticky_r; // result ready flag
  // gain loop state
  logic signed [ddcpm_pkg::AGC_W-1:0] c_i_r; // cic stage i
  logic signed [ddcpm_pkg::AGC_W-1:0] c_q_r; // cic stage q
  logic c_v_r; // cic stage valid
  logic [ddcpm_pkg::ACC_W-1:0] g_acc_r; // gain accumulator
  logic sat_r; // last output clipped
  logic [3:0] zero_run_r; // consecutive zero outputs
  logic [3:0] sat_run_r; // consecutive full-scale outputs

  // field views
  logic cdma; // cdma mode selected
  logic freeze; // loop frozen
  logic [7:0] dly_val; // sync delay in samples
  logic [7:0] intv_val; // interval in 1024-sample units
  logic [17:0] intv_lim; // interval in samples
  logic [3:0] rnd_val; // rounding setting
  logic [3:0] zmsk_val; // zero mask
  logic [7:0] thr_val; // threshold
  logic [3:0] zcnt_val; // zero occurrences needed
  logic [3:0] mcnt_val; // full-scale occurrences needed
  assign cdma = ctl_r[ddcpm_pkg::CTL_CDMA_BIT];
  assign freeze = ctl_r[ddcpm_pkg::CTL_FREEZE_BIT];
  assign dly_val = pm_dly_r[ddcpm_pkg::DLY_LSB +: 8];
  assign intv_val = pm_dly_r[ddcpm_pkg::INTV_LSB +: 8];
  assign intv_lim = {intv_val, 10'h000};
  assign rnd_val = thr_r[ddcpm_pkg::RND_LSB +: 4];
  assign zmsk_val = thr_r[ddcpm_pkg::ZMSK_LSB +: 4];
  assign thr_val = thr_r[ddcpm_pkg::THR_LSB +: 8];
  assign zcnt_val = ctl_r[ddcpm_pkg::CTL_ZCNT_LSB +: 4];
  assign mcnt_val = ctl_r[ddcpm_pkg::CTL_MCNT_LSB +: 4];
  assign o_test_ena = misc_r[ddcpm_pkg::TEST_BIT];

  // square of a signed sample, never negative
  function automatic logic [31:0] sq(input logic signed [15:0] x);
    logic signed [31:0] p;
    p = x * x;
    return $unsigned(p);
  endfunction : sq

  // round away rnd low bits, clip to 18 bits, flag clipping
  function automatic logic [18:0] rnd18(input logic signed [22:0] x,
                                        input logic [3:0] r);
    logic signed [23:0] t;
    logic signed [23:0] half;
    logic [17:0] m;
    logic [17:0] o;
    logic c;
    half = (r == 4'h0) ? 24'sh00_0000 : (24'sh00_0001 <<< (r - 4'h1));
    t = {x[22], x} + half;
    c = 1'b0;
    if (t > 24'sh01_ffff) begin
      o = 18'h1_ffff; // clip high
      c = 1'b1;
    end else if (t < -24'sh02_0000) begin
      o = 18'h2_0000; // clip low
      c = 1'b1;
    end else begin
      o = t[17:0];
    end
    m = ~((18'h0_0001 << r) - 18'h0_0001);
    return {c, o & m};
  endfunction : rnd18

  // magnitude of an 18-bit value, clamped to 17 bits
  function automatic logic [16:0] mag17(input logic signed [17:0] x);
    logic [17:0] a;
    a = x[17] ? 18'(-x) : 18'(x);
    return a[17] ? 17'h1_ffff : a[16:0];
  endfunction : mag17

  // register writes; loop clear is self-clearing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pm_len_r <= ddcpm_pkg::RST_ZERO;
      pm_dly_r <= ddcpm_pkg::RST_ZERO;
      cic_r <= ddcpm_pkg::RST_ZERO;
      misc_r <= ddcpm_pkg::RST_ZERO;
      step_r <= ddcpm_pkg::RST_ZERO;
      thr_r <= ddcpm_pkg::RST_ZERO;
      ctl_r <= ddcpm_pkg::RST_AGC_CTL;
      gain_r <= ddcpm_pkg::RST_GAIN;
    end else begin
      ctl_r[ddcpm_pkg::CTL_CLEAR_BIT] <= 1'b0;
      if (i_wr) begin
        if (i_addr == ddcpm_pkg::REG_PM_LEN) begin
          pm_len_r <= i_wr_data;
        end else if (i_addr == ddcpm_pkg::REG_PM_DLY) begin
          pm_dly_r <= i_wr_data;
        end else if (i_addr == ddcpm_pkg::REG_CIC) begin
          cic_r <= i_wr_data;
        end else if (i_addr == ddcpm_pkg::REG_MISC) begin
          misc_r <= i_wr_data;
        end else if (i_addr == ddcpm_pkg::REG_AGC_STEP) begin
          step_r <= i_wr_data;
        end else if (i_addr == ddcpm_pkg::REG_AGC_THR) begin
          thr_r <= i_wr_data;
        end else if (i_addr == ddcpm_pkg::REG_AGC_CTL) begin
          ctl_r <= i_wr_data;
        end else if (i_addr == ddcpm_pkg::REG_AGC_GAIN) begin
          gain_r <= i_wr_data;
        end
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data <= ddcpm_pkg::RST_ZERO;
    end else if (i_rd) begin
      if (i_addr == ddcpm_pkg::REG_PM_LEN) begin
        o_rd_data <= pm_len_r;
      end else if (i_addr == ddcpm_pkg::REG_PM_DLY) begin
        o_rd_data <= pm_dly_r;
      end else if (i_addr == ddcpm_pkg::REG_CIC) begin
        o_rd_data <= cic_r;
      end else if (i_addr == ddcpm_pkg::REG_MISC) begin
        o_rd_data <= misc_r;
      end else if (i_addr == ddcpm_pkg::REG_AGC_STEP) begin
        o_rd_data <= step_r;
      end else if (i_addr == ddcpm_pkg::REG_AGC_THR) begin
        o_rd_data <= thr_r;
      end else if (i_addr == ddcpm_pkg::REG_TOT_A0) begin
        o_rd_data <= tot_a_r[15:0];
      end else if (i_addr == ddcpm_pkg::REG_TOT_A1) begin
        o_rd_data <= tot_a_r[31:16];
      end else if (i_addr == ddcpm_pkg::REG_TOT_A2) begin
        o_rd_data <= tot_a_r[47:32];
      end else if (i_addr == ddcpm_pkg::REG_TOT_B0) begin
        o_rd_data <= tot_b_r[15:0];
      end else if (i_addr == ddcpm_pkg::REG_TOT_B1) begin
        o_rd_data <= tot_b_r[31:16];
      end else if (i_addr == ddcpm_pkg::REG_TOT_B2) begin
        o_rd_data <= tot_b_r[47:32];
      end else if (i_addr == ddcpm_pkg::REG_STATUS) begin
        o_rd_data <= {14'h0000, pm_st_r != ddcpm_pkg::PM_IDLE,
                      done_sticky_r};
      end else if (i_addr == ddcpm_pkg::REG_AGC_CTL) begin
        o_rd_data <= ctl_r;
      end else if (i_addr == ddcpm_pkg::REG_AGC_GAIN) begin
        o_rd_data <= gain_r;
      end else if (i_addr == ddcpm_pkg::REG_AGC_CUR) begin
        o_rd_data <= g_acc_r[ddcpm_pkg::ACC_EXT +: ddcpm_pkg::GAIN_W];
      end else begin
        o_rd_data <= ddcpm_pkg::RST_ZERO;
      end
    end
  end

  // meter control terms
  logic sync_go; // accepted sync pulse
  logic v; // sample arrives
  logic set_end; // a four-sample set completes
  logic fin; // integration completes this cycle
  logic intv_wrap; // interval limit reached
  logic start; // begin a fresh integration
  assign sync_go = i_pm_sync & ~ctl_r[ddcpm_pkg::CTL_SYNC_DIS_BIT];
  assign v = i_smp.valid;
  // cdma: one valid carries four samples; umts: two valids per set
  assign set_end = v & (cdma | half_r);
  assign fin = (pm_st_r == ddcpm_pkg::PM_RUN) & set_end &
               (set_cnt_r + 16'h0001 == pm_len_r);
  // zero interval means one-shot: no restart without a new sync
  assign intv_wrap = v & (intv_val != 8'h00) &
                     (pm_st_r == ddcpm_pkg::PM_RUN ||
                      pm_st_r == ddcpm_pkg::PM_HOLD) &
                     (intv_cnt_r + 18'h0_0001 == intv_lim);
  // restart: at sync with no delay, delay elapsed, or interval wrap
  assign start = (sync_go & (dly_val == 8'h00)) |
                 (~sync_go & (pm_st_r == ddcpm_pkg::PM_DELAY) & v &
                  (dly_cnt_r + 8'h01 == dly_val)) |
                 (~sync_go & intv_wrap);

  // meter sequencing: delay, run, hold until interval wraps
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pm_st_r <= ddcpm_pkg::PM_IDLE;
      dly_cnt_r <= 8'h00;
      intv_cnt_r <= 18'h0_0000;
      set_cnt_r <= 16'h0000;
      half_r <= 1'b0;
    end else if (start) begin
      pm_st_r <= ddcpm_pkg::PM_RUN;
      intv_cnt_r <= 18'h0_0000;
      set_cnt_r <= 16'h0000;
      half_r <= 1'b0;
    end else if (sync_go) begin
      pm_st_r <= ddcpm_pkg::PM_DELAY;
      dly_cnt_r <= 8'h00;
    end else begin
      case (pm_st_r)
        ddcpm_pkg::PM_DELAY: begin
          if (v) begin
            dly_cnt_r <= dly_cnt_r + 8'h01;
          end
        end
        ddcpm_pkg::PM_RUN: begin
          if (v) begin
            intv_cnt_r <= intv_cnt_r + 18'h0_0001;
            half_r <= ~cdma & ~half_r;
          end
          if (fin) begin
            pm_st_r <= ddcpm_pkg::PM_HOLD;
          end else if (set_end) begin
            set_cnt_r <= set_cnt_r + 16'h0001;
          end
        end
        ddcpm_pkg::PM_HOLD: begin
          if (v) begin
            intv_cnt_r <= intv_cnt_r + 18'h0_0001;
          end
        end
        default: begin
          pm_st_r <= ddcpm_pkg::PM_IDLE;
        end
      endcase
    end
  end

  // per-sample power terms
  logic [32:0] pw_a; // signal i/q power
  logic [32:0] pw_b; // diversity i/q power
  assign pw_a = {1'b0, sq(i_smp.ia)} + {1'b0, sq(i_smp.qa)};
  assign pw_b = {1'b0, sq(i_smp.ib)} + {1'b0, sq(i_smp.qb)};

  // running totals; totals wrap past 48 bits
  always_ff @(posedge i_clk) begin
    if (i_rst || start) begin
      acc_a_r <= '0;
      acc_b_r <= '0;
    end else if (pm_st_r == ddcpm_pkg::PM_RUN && v) begin
      acc_a_r <= acc_a_r + 48'(pw_a);
      acc_b_r <= cdma ? acc_b_r + 48'(pw_b) : acc_b_r;
    end
  end

  // publish on completion; held so reads see one finished result
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tot_a_r <= '0;
      tot_b_r <= '0;
      o_pm_done <= 1'b0;
    end else begin
      o_pm_done <= fin;
      if (fin) begin
        tot_a_r <= acc_a_r + 48'(pw_a);
        tot_b_r <= cdma ? acc_b_r + 48'(pw_b) : '0;
      end
    end
  end

  // result flag: reading status clears it, a completion wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_sticky_r <= 1'b0;
    end else if (fin) begin
      done_sticky_r <= 1'b1;
    end else if (i_rd && i_addr == ddcpm_pkg::REG_STATUS) begin
      done_sticky_r <= 1'b0;
    end
  end

  // cic output stage: x4 for the fixed gain option
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      c_v_r <= 1'b0;
      c_i_r <= '0;
      c_q_r <= '0;
    end else begin
      c_v_r <= i_smp.valid;
      if (cic_r[ddcpm_pkg::CIC_GAIN_BIT]) begin
        c_i_r <= 18'(i_smp.ia) <<< ddcpm_pkg::CIC_SHIFT;
        c_q_r <= 18'(i_smp.qa) <<< ddcpm_pkg::CIC_SHIFT;
      end else begin
        c_i_r <= 18'(i_smp.ia);
        c_q_r <= 18'(i_smp.qa);
      end
    end
  end

  // multiply by current gain and round
  logic signed [34:0] p_i; // product i
  logic signed [34:0] p_q; // product q
  logic [18:0] r_i; // rounded i with clip flag
  logic [18:0] r_q; // rounded q with clip flag
  logic [16:0] g_cur; // gain in use, 4.12 unsigned
  assign g_cur = {1'b0, g_acc_r[ddcpm_pkg::ACC_EXT +: ddcpm_pkg::GAIN_W]};
  assign p_i = c_i_r * $signed(g_cur);
  assign p_q = c_q_r * $signed(g_cur);
  assign r_i = rnd18(p_i[34:ddcpm_pkg::GAIN_FRAC], rnd_val);
  assign r_q = rnd18(p_q[34:ddcpm_pkg::GAIN_FRAC], rnd_val);

  // registered loop output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_agc <= '0;
      sat_r <= 1'b0;
    end else begin
      o_agc.valid <= c_v_r;
      if (c_v_r) begin
        o_agc.i <= r_i[17:0];
        o_agc.q <= r_q[17:0];
        sat_r <= r_i[18] | r_q[18];
      end
    end
  end

  // level detection on the larger of |i| and |q|
  logic [16:0] mag; // output magnitude
  logic [7:0] top8; // upper eight magnitude bits
  logic is_zero; // masked magnitude is zero
  logic is_sat; // output at full scale
  assign mag = (mag17(o_agc.i) > mag17(o_agc.q)) ? mag17(o_agc.i) :
               mag17(o_agc.q);
  assign top8 = mag[ddcpm_pkg::TOP8_LSB +: 8];
  assign is_zero = (mag & ~{13'h0000, zmsk_val}) == 17'h0_0000;
  assign is_sat = sat_r | (mag == 17'h1_ffff);

  // consecutive zero and full-scale counts
  logic zero_hit; // zero persisted long enough
  logic sat_hit; // full scale persisted long enough
  assign zero_hit = is_zero & (zero_run_r + 4'h1 >= zcnt_val);
  assign sat_hit = is_sat & (sat_run_r + 4'h1 >= mcnt_val);
  always_ff @(posedge i_clk) begin
    if (i_rst || freeze) begin
      zero_run_r <= 4'h0;
      sat_run_r <= 4'h0;
    end else if (o_agc.valid) begin
      zero_run_r <= (is_zero && !zero_hit) ? zero_run_r + 4'h1 : 4'h0;
      sat_run_r <= (is_sat && !sat_hit) ? sat_run_r + 4'h1 : 4'h0;
    end
  end

  // gain step terms, shifted copies of the accumulator
  logic [ddcpm_pkg::ACC_W:0] up_s; // add candidate
  logic [ddcpm_pkg::ACC_W-1:0] dn_s; // subtract result
  logic [3:0] up_sh; // shift for an increase
  logic [3:0] dn_sh; // shift for a decrease
  assign up_sh = zero_hit ? step_r[ddcpm_pkg::DZERO_LSB +: 4] :
                 step_r[ddcpm_pkg::DBELOW_LSB +: 4];
  assign dn_sh = sat_hit ? step_r[ddcpm_pkg::DSAT_LSB +: 4] :
                 step_r[ddcpm_pkg::DABOVE_LSB +: 4];
  assign up_s = {1'b0, g_acc_r} + {1'b0, g_acc_r >> up_sh};
  assign dn_s = g_acc_r - (g_acc_r >> dn_sh);

  // adapt: full scale first, then zero, then threshold compare
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      g_acc_r <= {ddcpm_pkg::RST_GAIN, 8'h00};
    end else if (freeze || ctl_r[ddcpm_pkg::CTL_CLEAR_BIT]) begin
      g_acc_r <= {gain_r, 8'h00};
    end else if (o_agc.valid) begin
      if (sat_hit) begin
        g_acc_r <= dn_s;
      end else if (zero_hit || top8 < thr_val) begin
        // clip at the top rather than wrap to a tiny gain
        g_acc_r <= up_s[ddcpm_pkg::ACC_W] ? '1 : up_s[23:0];
      end else if (top8 > thr_val) begin
        g_acc_r <= dn_s;
      end
    end
  end

endmodule : ddcpm_top

// file: bench/ddcpm_assertions.sv
// port checks for the ddc power meter and gain loop
`timescale 1ns/1ps
module ddcpm_checker (
  input wire logic i_clk, // clock
  input wire logic i_rst, // sync reset
  input wire logic [7:0] i_addr, // address
  input wire logic [15:0] i_wr_data, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [15:0] o_rd_data, // read data
  input wire logic i_pm_sync, // meter sync
  input wire ddcpm_pkg::ddcpm_smp_t i_smp, // samples in
  input wire ddcpm_pkg::ddcpm_agc_t o_agc, // gain loop out
  input wire logic o_pm_done, // done pulse
  input wire logic o_test_ena // test bit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [15:0] len_r; // mirror of the length register
  // mirror the length so reads and completions can be judged
  always_ff @(posedge i_clk) begin
    if (i_rst) len_r <= 16'h0000;
    else if (i_wr && i_addr == 8'h02) len_r <= i_wr_data;
  end
  a_agc_latency: assert property (i_smp.valid |-> ##2 o_agc.valid)
    else $error("gain loop output missing");
  a_agc_spurious: assert property (o_agc.valid |-> $past(i_smp.valid, 2))
    else $error("gain loop output without sample");
  a_agc_zero: assert property (i_smp.valid && i_smp.ia == 16'h0000 &&
    i_smp.qa == 16'h0000 |-> ##2 o_agc.i == 18'h0_0000 && o_agc.q == 18'h0_0000)
    else $error("zero input gave nonzero output");
  a_done_pulse: assert property (o_pm_done |=> !o_pm_done)
    else $error("done longer than one cycle");
  a_done_cause: assert property (o_pm_done |-> $past(i_smp.valid))
    else $error("done without a final sample");
  a_done_len: assert property (o_pm_done |-> len_r != 16'h0000)
    else $error("zero length completed");
  a_test_bit: assert property (i_wr && i_addr == 8'h19 |=> o_test_ena == $past(i_wr_data[10]))
    else $error("test bit not taken from write");
  a_test_hold: assert property (!(i_wr && i_addr == 8'h19) |=> $stable(o_test_ena))
    else $error("test bit changed without write");
  a_rd_hold: assert property (!i_rd |=> $stable(o_rd_data))
    else $error("read data changed without read");
  a_len_read: assert property (i_rd && i_addr == 8'h02 |=> o_rd_data == len_r)
    else $error("length read back wrong");
  a_unmapped: assert property (i_rd && i_addr == 8'h40 |=> o_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  c_done: cover property (o_pm_done);
  c_agc: cover property (o_agc.valid);
  c_sync: cover property (i_pm_sync ##[1:20] i_smp.valid);
endmodule : ddcpm_checker

// file: bench/ddcpm_src.sv
// model of the upstream filter chain feeding samples
`timescale 1ns/1ps
module ddcpm_src (
  input wire logic i_clk, // clock
  input wire logic i_go, // send one sample
  input wire logic [63:0] i_val, // ia, qa, ib, qb
  output ddcpm_pkg::ddcpm_smp_t o_smp // sample out
);
  ddcpm_pkg::ddcpm_smp_t smp_r = '0; // held sample
  // one valid per request; idle data toggles so stale words never match
  always @(posedge i_clk) begin
    smp_r <= i_go ? {1'b1, i_val} : {1'b0, ~smp_r[63:0]};
  end
  assign o_smp = smp_r;
endmodule : ddcpm_src

// file: bench/testbench.sv
// self-checking bench for the power meter and gain loop
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [15:0] g, s, t, c, a, b; // gain, steps, thr, ctl, inputs
    logic [17:0] x, y; // expected outputs
  } ddcpm_case_t;
  logic i_clk = 1'b0; // clock
  logic i_rst = 1'b1; // sync reset
  logic [7:0] i_addr = 8'h00; // address
  logic [15:0] i_wr_data = 16'h0000; // write data
  logic i_wr = 1'b0; // write strobe
  logic i_rd = 1'b0; // read strobe
  logic i_pm_sync = 1'b0; // meter sync
  logic src_go = 1'b0; // sample request
  logic [63:0] src_val = 64'h0; // sample words
  logic [15:0] o_rd_data; // read data
  ddcpm_pkg::ddcpm_smp_t smp; // source to block
  ddcpm_pkg::ddcpm_agc_t o_agc; // gain loop out
  logic o_pm_done; // done pulse
  logic o_test_ena; // test bit
  int n_mismatch = 0; // mismatches
  int samples_checked = 0; // comparisons
  int n_done = 0; // done pulses
  logic [15:0] d; // read word
  logic [47:0] t; // total
  logic [17:0] o1, o2; // loop outputs
  logic [7:0] regs [6] = '{8'h02, 8'h03, 8'h0e, 8'h1d, 8'h1e, 8'h19};
  // below, above, masked, full scale, zero run, frozen
  ddcpm_case_t cases [6] = '{
    '{16'h1000, 16'h1000, 16'h0010, 16'h0000, 16'h03e8, 16'h03e8,
      18'h0_03e8, 18'h0_05dc},
    '{16'h1000, 16'h0200, 16'h0200, 16'h0000, 16'h03e8, 16'h03e8,
      18'h0_03e8, 18'h0_02f0},
    '{16'h1000, 16'h0010, 16'hf000, 16'h0000, 16'h0005, 16'h03e8,
      18'h0_0005, 18'h0_05dc},
    '{16'h8000, 16'h0201, 16'h0000, 16'h0000, 16'h7fff, 16'h03e8,
      18'h1_ffff, 18'h0_0fa0},
    '{16'h1000, 16'h0010, 16'hf000, 16'h0020, 16'h0005, 16'h0005,
      18'h0_0005, 18'h0_0005},
    '{16'h1000, 16'h1000, 16'h0010, 16'h0001, 16'h03e8, 16'h03e8,
      18'h0_03e8, 18'h0_03e8}};
  always #4 i_clk = ~i_clk;
  // count completions for the meter scenarios
  always @(posedge i_clk) if (o_pm_done === 1'b1) n_done <= n_done + 1;
  ddcpm_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_pm_sync(i_pm_sync), .i_smp(smp), .o_agc(o_agc),
    .o_pm_done(o_pm_done), .o_test_ena(o_test_ena));
  ddcpm_src src (.i_clk(i_clk), .i_go(src_go), .i_val(src_val), .o_smp(smp));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string w, input logic [47:0] s, input logic [47:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rd_data;
  endtask : rd
  task automatic rdc(input string w, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(w, 48'(v), 48'(e));
  endtask : rdc
  // totals are read low word first
  task automatic tot(input logic [7:0] a, output logic [47:0] v);
    logic [15:0] w;
    for (int k = 0; k < 3; k++) begin
      rd(a + 8'(k), w);
      v[16*k +: 16] = w;
    end
  endtask : tot
  task automatic sync;
    @(posedge i_clk);
    i_pm_sync <= 1'b1;
    @(posedge i_clk);
    i_pm_sync <= 1'b0;
  endtask : sync
  task automatic put(input logic [63:0] v);
    @(posedge i_clk);
    src_go <= 1'b1;
    src_val <= v;
    @(posedge i_clk);
    src_go <= 1'b0;
  endtask : put
  task automatic wait_done(input int n);
    for (int k = 0; k < 60 && n_done < n; k++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
    chk("done count", 48'(n_done), 48'(n));
    if (n_done < n) end_sim();
  endtask : wait_done
  // one sample through the loop and its gain decision
  task automatic agc(input logic [15:0] a, output logic [17:0] o);
    int k;
    put({a, 48'h0});
    for (k = 0; k < 8 && o_agc.valid !== 1'b1; k++) @(posedge i_clk) #1;
    if (k == 8) chk("agc wait", 48'h0, 48'h1);
    if (k == 8) end_sim();
    o = o_agc.i;
    chk("q", 48'(o_agc.q), 48'h0);
    repeat (3) @(posedge i_clk);
  endtask : agc
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc("len rst", 8'h02, 16'h0000);
    rdc("delay rst", 8'h03, 16'h0000);
    rdc("step rst", 8'h1d, 16'h0000);
    rdc("thr rst", 8'h1e, 16'h0000);
    rdc("ctl rst", 8'h27, ddcpm_pkg::RST_AGC_CTL);
    rdc("gain rst", 8'h28, ddcpm_pkg::RST_GAIN);
    rdc("unmapped", 8'h40, 16'h0000);
    foreach (regs[i]) begin
      wr(regs[i], 16'ha5c3);
      rdc("readback", regs[i], 16'ha5c3);
    end
    chk("test bit", 48'(o_test_ena), 48'h1);
    foreach (regs[i]) wr(regs[i], 16'h0000);
    #1 chk("test bit", 48'(o_test_ena), 48'h0);
    // signal and diversity powers, one set
    wr(8'h02, 16'h0001);
    wr(8'h27, 16'h0005);
    sync();
    put({16'h0003, 16'h0004, 16'h0001, 16'h0002});
    wait_done(1);
    tot(8'h20, t);
    chk("total a", t, 48'h0019);
    tot(8'h23, t);
    chk("total b", t, 48'h0005);
    rd(8'h26, d);
    chk("done flag", 48'(d[0]), 48'h1);
    rd(8'h26, d);
    chk("done cleared", 48'(d[0]), 48'h0);
    tot(8'h20, t);
    chk("total held", t, 48'h0019);
    // delayed start: second sample starts, next two counted
    wr(8'h02, 16'h0002);
    wr(8'h03, 16'h0200);
    sync();
    for (int k = 1; k < 5; k++) put({16'(k), 32'h0, 16'(k)});
    wait_done(2);
    tot(8'h20, t);
    chk("delayed a", t, 48'h0019);
    tot(8'h23, t);
    chk("delayed b", t, 48'h0019);
    // single total, two pairs per set
    wr(8'h02, 16'h0001);
    wr(8'h03, 16'h0000);
    wr(8'h27, 16'h0001);
    sync();
    put({16'h0002, 16'h0001, 32'h0});
    put({16'h0001, 16'h0003, 32'h0});
    wait_done(3);
    tot(8'h20, t);
    chk("single a", t, 48'h000f);
    tot(8'h23, t);
    chk("single b", t, 48'h0000);
    // interval of 1024 samples restarts the count once
    wr(8'h03, 16'h0001);
    wr(8'h27, 16'h0005);
    sync();
    repeat (1030) put(64'h0);
    wait_done(5);
    wr(8'h03, 16'h0000);
    foreach (cases[i]) begin
      wr(8'h28, cases[i].g);
      wr(8'h1d, cases[i].s);
      wr(8'h1e, cases[i].t);
      wr(8'h27, 16'h0001);
      wr(8'h27, cases[i].c);
      agc(cases[i].a, o1);
      agc(cases[i].b, o2);
      chk("agc first", 48'(o1), 48'(cases[i].x));
      chk("agc next", 48'(o2), 48'(cases[i].y));
    end
    wr(8'h0e, 16'h0020);
    agc(16'h0064, o1);
    chk("cic gain", 48'(o1), 48'h0190);
    end_sim();
  end
endmodule : testbench
bind ddcpm_top ddcpm_checker u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
  .o_rd_data(o_rd_data), .i_pm_sync(i_pm_sync), .i_smp(i_smp),
  .o_agc(o_agc), .o_pm_done(o_pm_done), .o_test_ena(o_test_ena));
